/* File: rtl/sss_pkg.sv */
// Overview of operation
// - Run gate needs run, cartridge, door, supply ok
// - Run gate rise sets spindle, starts delay
// - Start delay counts seconds, saturates at eight
// - Head load needs on-speed and count eight
// - Ready flop clocked by on-cylinder, drives ready
// - Load position drops run, enables stopped counter
// - Pulses clear stopped counter; two unlocks door
// - Run gate low clears start delay counter
// - Head load removal drops ready, retracts heads
// - Heads home resets spindle motor latch
// - Index retriggers low-speed timeout; expiry drops speed
// - Head load removal fires 40 us stop strobe
// - Missing line AC for 45 ms asserts low
// - After line low, end at next sector
// - Supply fail drops run, safety relay, flags low
// - Binary type: 3-bit code, one-of-eight match
// - Selected-ready needs match, ready, no fault
// - Linear type: one-hot lines, positions 0-3
// - On-cylinder only after 6 ms settle
package sss_pkg;

    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned SLOW_TICK_S    = 1;
    localparam int unsigned LOW_SPEED_MS   = 45;
    localparam int unsigned LINE_POWER_LOW_OUT_MS      = 45;
    localparam int unsigned SETTLE_MS      = 6;
    localparam int unsigned STOP_STROBE_US = 40;

    localparam int unsigned SLOW_TICK_CYC  = SLOW_TICK_S * CLK_HZ;
    localparam int unsigned LOW_SPEED_CYC  = LOW_SPEED_MS * (CLK_HZ / 1000);
    localparam int unsigned LINE_POWER_LOW_OUT_CYC     = LINE_POWER_LOW_OUT_MS * (CLK_HZ / 1000);
    localparam int unsigned SETTLE_CYC     = SETTLE_MS * (CLK_HZ / 1000);
    localparam int unsigned STROBE_CYC     = STOP_STROBE_US * (CLK_HZ / 1_000_000);

    localparam int          TMR_W          = 25;
    localparam logic [3:0]  START_SAT      = 4'h8;
    localparam logic [1:0]  STOPPED_SAT    = 2'h2;
    localparam logic [2:0]  UNIT_RST       = 3'h0;
    localparam logic [31:0] CTRL_OFS       = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFS     = 32'h0000_0004;
    localparam int          CTRL_UNIT_LSB  = 0;
    localparam int          CTRL_FCLR_BIT  = 3;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;

    typedef struct packed {
        logic run_switch;
        logic cartridge_seated;
        logic door_locked;
        logic supply_ok;
        logic line_ac_present;
        logic sector_pulse;
        logic index_pulse;
        logic heads_home;
        logic head_motion;
        logic fault_detect;
    } sss_pins_t;

    // Pin levels held at reset: supply and line AC good, heads home
    localparam sss_pins_t PINS_IDLE = 10'h064;

    typedef struct packed {
        logic drive_ready;
        logic select_ready;
        logic line_power_low_out;
        logic supply_low_out;
        logic ready_lamp;
        logic load_lamp;
        logic on_cylinder_lamp;
        logic spindle_relay;
        logic door_unlock;
        logic head_load;
        logic retract_heads;
        logic safety_relay;
    } sss_drive_t;

    typedef struct packed {
        logic [2:0] unit;
        logic       fault;
        logic [1:0] stopped_cnt;
        logic [3:0] start_cnt;
        logic       on_speed;
        logic       run_gate;
        sss_drive_t drive;
    } sss_status_t;

    // One-shot countdown: load on trigger, else run down to zero
    function automatic logic [TMR_W-1:0] tmr_step(input logic [TMR_W-1:0] cur,
                                                  input logic             trig,
                                                  input logic [TMR_W-1:0] load);
        if (trig) begin
            return load;
        end
        return (cur != '0) ? cur - 1'b1 : cur;
    endfunction

endpackage

/* File: rtl/sss_top.sv */
`timescale 1ns/1ps
module sss_top #(
    parameter int unsigned SLOW_CYCLES  = sss_pkg::SLOW_TICK_CYC,
    parameter int unsigned LOW_CYCLES   = sss_pkg::LOW_SPEED_CYC,
    parameter int unsigned AC_CYCLES    = sss_pkg::LINE_POWER_LOW_OUT_CYC,
    parameter int unsigned SETTLE_CYCLES = sss_pkg::SETTLE_CYC
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire sss_pkg::sss_pins_t pins,
    input  wire logic               binary_select_type_n,
    input  wire logic [3:0]         unit_select_line_n,
    output sss_pkg::sss_drive_t     drive,
    input  wire logic [31:0]        awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [31:0]        araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready
);
    import sss_pkg::*;

    localparam logic [TMR_W-1:0] SLOW_LD   = TMR_W'(SLOW_CYCLES - 1);
    localparam logic [TMR_W-1:0] LOW_LD    = TMR_W'(LOW_CYCLES);
    localparam logic [TMR_W-1:0] AC_LD     = TMR_W'(AC_CYCLES);
    localparam logic [TMR_W-1:0] SETTLE_LD = TMR_W'(SETTLE_CYCLES);
    localparam logic [TMR_W-1:0] STROBE_LD = TMR_W'(STROBE_CYC);
    localparam logic [TMR_W-1:0] TMR_ONE   = TMR_W'(1);

    sss_pins_t        pins_m_reg;
    sss_pins_t        pins_s_reg;
    sss_pins_t        pins_d_reg;
    logic             sec_rise;
    logic             idx_rise;
    logic             home_rise;
    logic             motion_fall;
    logic [TMR_W-1:0] tick_cnt_reg;
    logic             tick_reg;
    logic             run_gate_reg;
    logic             spindle_reg;
    logic [3:0]       start_cnt_reg;
    logic [TMR_W-1:0] low_tmr_reg;
    logic [TMR_W-1:0] low_tmr_next;
    logic             on_speed_reg;
    logic [TMR_W-1:0] ac_tmr_reg;
    logic             line_power_low_out_reg;
    logic             ac_stop_reg;
    logic             head_load_reg;
    logic [TMR_W-1:0] strobe_tmr_reg;
    logic [TMR_W-1:0] settle_tmr_reg;
    logic             on_cylinder_lamp_reg;
    logic             ready_reg;
    logic [1:0]       stopped_cnt_reg;
    logic             door_unlock_reg;
    logic [2:0]       unit_reg;
    logic             fault_reg;
    logic             fault_clr;
    logic             unit_match;
    logic             sel_ready_reg;
    logic [31:0]      aw_addr_reg;
    logic [31:0]      w_data_reg;
    logic [3:0]       w_strb_reg;
    sss_status_t      status;

    // Input synchronisers, plus one stage for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_m_reg <= PINS_IDLE;
            pins_s_reg <= PINS_IDLE;
            pins_d_reg <= PINS_IDLE;
        end else begin
            pins_m_reg <= pins;
            pins_s_reg <= pins_m_reg;
            pins_d_reg <= pins_s_reg;
        end
    end

    assign sec_rise    = pins_s_reg.sector_pulse & ~pins_d_reg.sector_pulse;
    assign idx_rise    = pins_s_reg.index_pulse & ~pins_d_reg.index_pulse;
    assign home_rise   = pins_s_reg.heads_home & ~pins_d_reg.heads_home;
    assign motion_fall = ~pins_s_reg.head_motion & pins_d_reg.head_motion;

    // Slow clock: one-cycle tick per second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg     <= (tick_cnt_reg == SLOW_LD);
            tick_cnt_reg <= (tick_cnt_reg == SLOW_LD) ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // Interlocks; supply fail drops the gate at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_gate_reg <= 1'b0;
        end else begin
            run_gate_reg <= pins_s_reg.run_switch & pins_s_reg.cartridge_seated
                          & pins_s_reg.door_locked & pins_s_reg.supply_ok;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spindle_reg <= 1'b0;
        end else if (home_rise) begin
            spindle_reg <= 1'b0;
        end else if (pins_s_reg.run_switch & pins_s_reg.cartridge_seated
                     & pins_s_reg.door_locked & pins_s_reg.supply_ok & ~run_gate_reg) begin
            spindle_reg <= 1'b1;
        end
    end

    // Start delay counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_cnt_reg <= '0;
        end else if (!run_gate_reg || strobe_tmr_reg != '0) begin
            start_cnt_reg <= '0;
        end else if (tick_reg && start_cnt_reg != START_SAT) begin
            start_cnt_reg <= start_cnt_reg + 1'b1;
        end
    end

    // Low-speed timeout; line-power stop ends it at a sector
    always_comb begin
        if (ac_stop_reg || (line_power_low_out_reg && sec_rise)) begin
            low_tmr_next = '0;
        end else begin
            low_tmr_next = tmr_step(low_tmr_reg, idx_rise, LOW_LD);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_tmr_reg  <= '0;
            on_speed_reg <= 1'b0;
        end else begin
            low_tmr_reg  <= low_tmr_next;
            on_speed_reg <= (low_tmr_next != '0);
        end
    end

    // Line power detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ac_tmr_reg  <= AC_LD;
            line_power_low_out_reg  <= 1'b0;
            ac_stop_reg <= 1'b0;
        end else begin
            ac_tmr_reg  <= tmr_step(ac_tmr_reg, pins_s_reg.line_ac_present, AC_LD);
            line_power_low_out_reg  <= (ac_tmr_reg == '0) && !pins_s_reg.line_ac_present;
            if (pins_s_reg.line_ac_present) begin
                ac_stop_reg <= 1'b0;
            end else if (line_power_low_out_reg && sec_rise) begin
                ac_stop_reg <= 1'b1;
            end
        end
    end

    // Head load and stop strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head_load_reg  <= 1'b0;
            strobe_tmr_reg <= '0;
        end else begin
            head_load_reg  <= on_speed_reg && (start_cnt_reg == START_SAT);
            strobe_tmr_reg <= tmr_step(strobe_tmr_reg,
                                       head_load_reg && !(on_speed_reg && (start_cnt_reg == START_SAT)),
                                       STROBE_LD);
        end
    end

    // Positioner settle, then on-cylinder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_tmr_reg <= '0;
            on_cylinder_lamp_reg     <= 1'b0;
        end else begin
            settle_tmr_reg <= pins_s_reg.head_motion ? '0
                              : tmr_step(settle_tmr_reg, motion_fall, SETTLE_LD);
            if (pins_s_reg.head_motion) begin
                on_cylinder_lamp_reg <= 1'b0;
            end else if (settle_tmr_reg == TMR_ONE) begin
                on_cylinder_lamp_reg <= 1'b1;
            end
        end
    end

    // Ready flop: data is head load, clock is on-cylinder rising
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_reg <= 1'b0;
        end else if (!head_load_reg) begin
            ready_reg <= 1'b0;
        end else if (!pins_s_reg.head_motion && settle_tmr_reg == TMR_ONE && !on_cylinder_lamp_reg) begin
            ready_reg <= 1'b1;
        end
    end

    // Disk stopped counter and door unlock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stopped_cnt_reg <= '0;
            door_unlock_reg <= 1'b0;
        end else begin
            if (pins_s_reg.run_switch || sec_rise || idx_rise) begin
                stopped_cnt_reg <= '0;
            end else if (tick_reg && stopped_cnt_reg != STOPPED_SAT) begin
                stopped_cnt_reg <= stopped_cnt_reg + 1'b1;
            end
            door_unlock_reg <= !pins_s_reg.run_switch && (stopped_cnt_reg == STOPPED_SAT);
        end
    end

    // Fault latch: a new fault wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_reg <= 1'b0;
        end else if (pins_s_reg.fault_detect) begin
            fault_reg <= 1'b1;
        end else if (fault_clr) begin
            fault_reg <= 1'b0;
        end
    end

    // Unit decode for both controller types
    always_comb begin
        if (!binary_select_type_n) begin
            unit_match = (~unit_select_line_n[2:0] == unit_reg);
        end else begin
            unit_match = !unit_reg[2] && !unit_select_line_n[unit_reg[1:0]];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ready_reg <= 1'b0;
        end else begin
            sel_ready_reg <= unit_match && ready_reg && !fault_reg;
        end
    end

    // Output register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive <= '0;
        end else begin
            drive.drive_ready        <= ready_reg;
            drive.ready_lamp         <= ready_reg;
            drive.select_ready       <= sel_ready_reg;
            drive.line_power_low_out <= line_power_low_out_reg;
            drive.supply_low_out     <= !pins_s_reg.supply_ok;
            drive.safety_relay       <= pins_s_reg.supply_ok;
            drive.load_lamp          <= door_unlock_reg;
            drive.door_unlock        <= door_unlock_reg;
            drive.on_cylinder_lamp   <= on_cylinder_lamp_reg;
            drive.spindle_relay      <= spindle_reg;
            drive.head_load          <= head_load_reg;
            drive.retract_heads      <= !head_load_reg;
        end
    end

    assign status = '{unit: unit_reg, fault: fault_reg, stopped_cnt: stopped_cnt_reg,
                      start_cnt: start_cnt_reg, on_speed: on_speed_reg,
                      run_gate: run_gate_reg, drive: drive};

    // AXI4-Lite write side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready     <= 1'b1;
            wready      <= 1'b1;
            bvalid      <= 1'b0;
            bresp       <= RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            unit_reg    <= UNIT_RST;
            fault_clr   <= 1'b0;
        end else begin
            fault_clr <= 1'b0;
            if (awvalid && awready) begin
                aw_addr_reg <= awaddr;
                awready     <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready     <= 1'b0;
            end
            if (!awready && !wready && !bvalid) begin
                bvalid <= 1'b1;
                bresp  <= RESP_OKAY;
                if ({aw_addr_reg[31:2], 2'b00} == CTRL_OFS) begin
                    if (w_strb_reg[0]) begin
                        unit_reg  <= w_data_reg[CTRL_UNIT_LSB +: 3];
                        fault_clr <= w_data_reg[CTRL_FCLR_BIT];
                    end
                end else if ({aw_addr_reg[31:2], 2'b00} != STATUS_OFS) begin
                    bresp <= RESP_DECERR;
                end
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= RESP_OKAY;
            rdata   <= '0;
            if ({araddr[31:2], 2'b00} == CTRL_OFS) begin
                rdata <= {28'h0000000, 1'b0, unit_reg};
            end else if ({araddr[31:2], 2'b00} == STATUS_OFS) begin
                rdata <= 32'(status);
            end else begin
                rresp <= RESP_DECERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RUN_GATE: assert property (!pins_s_reg.door_locked |=> !run_gate_reg)
        else $error("run gate open with door unlocked");
    AST_SPINDLE_SET: assert property ($rose(run_gate_reg) |-> spindle_reg || $past(home_rise))
        else $error("spindle not set with run gate");
    AST_START_SAT: assert property (start_cnt_reg == START_SAT && run_gate_reg
                                    && strobe_tmr_reg == '0 |=> start_cnt_reg == START_SAT)
        else $error("start delay left saturation");
    AST_HEAD_LOAD: assert property (head_load_reg |-> $past(on_speed_reg) && $past(start_cnt_reg) == START_SAT)
        else $error("head load without speed and delay");
    AST_READY_SET: assert property ($rose(ready_reg) |-> head_load_reg && on_cylinder_lamp_reg)
        else $error("ready set without on-cylinder");
    AST_STOPPED_CLR: assert property (idx_rise |=> stopped_cnt_reg == '0)
        else $error("stopped counter not cleared by index");
    AST_RUN_CLEAR: assert property (!run_gate_reg |=> start_cnt_reg == '0)
        else $error("start delay not cleared");
    AST_READY_DROP: assert property (!head_load_reg |=> !ready_reg ##1 !drive.drive_ready)
        else $error("ready held after head load removal");
    AST_HOME_STOP: assert property (home_rise |=> !spindle_reg)
        else $error("spindle kept on at home");
    AST_STROBE: assert property ($fell(head_load_reg) |=> (strobe_tmr_reg != '0)[*8])
        else $error("stop strobe too short");
    AST_DC_LOW: assert property (!pins_s_reg.supply_ok |=> drive.supply_low_out && !drive.safety_relay && !run_gate_reg)
        else $error("supply fail not handled");
    AST_SELECT: assert property (sel_ready_reg |-> $past(ready_reg) && !$past(fault_reg))
        else $error("selected-ready without ready");
    AST_SETTLE: assert property ($rose(on_cylinder_lamp_reg) |-> $past(settle_tmr_reg) == TMR_ONE)
        else $error("on-cylinder before settle");

    COV_HEAD_LOAD: cover property ($rose(head_load_reg));
    COV_READY: cover property ($rose(drive.drive_ready));
    COV_DOOR: cover property ($rose(drive.door_unlock));
    COV_LINE_LOW: cover property ($rose(drive.line_power_low_out));

endmodule

/* File: bench/sss_ctrl_model.sv */
`timescale 1ns/1ps
module sss_ctrl_model (
    input  wire logic       aclk,
    input  wire logic       bin_mode,
    input  wire logic [2:0] unit,
    output logic            binary_select_type_n,
    output logic [3:0]      unit_select_line_n
);
    logic spare;
    initial begin
        spare = 1'b0;
        binary_select_type_n = 1'b0;
        unit_select_line_n = 4'hF;
    end
    // Unused top line toggles in binary mode so it never looks stable
    always @(posedge aclk) begin
        spare <= ~spare;
        binary_select_type_n <= ~bin_mode;
        if (bin_mode) begin
            unit_select_line_n <= {spare, ~unit};
        end else begin
            unit_select_line_n <= ~(4'h1 << unit[1:0]);
        end
    end
endmodule

/* File: bench/test_sss_top.sv */
`timescale 1ns/1ps
module test_sss_top;
    import sss_pkg::*;
    localparam int DR = 11, SR = 10, LP = 9, SL = 8, SP = 4, DU = 3, HL = 2, RH = 1, SF = 0;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, cm_bin, spin_on, sel_type_n;
    logic [2:0]  cm_unit;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [3:0]  wstrb, sel_n;
    logic [1:0]  bresp, rresp, r;
    sss_pins_t   pins;
    sss_drive_t  drive;
    int          errors, tests_run, ph;

    sss_ctrl_model ctl (.aclk(aclk), .bin_mode(cm_bin), .unit(cm_unit),
        .binary_select_type_n(sel_type_n), .unit_select_line_n(sel_n));
    sss_top #(.SLOW_CYCLES(20), .LOW_CYCLES(40), .AC_CYCLES(30), .SETTLE_CYCLES(10)) uut (
        .aclk(aclk), .aresetn(aresetn), .pins(pins), .binary_select_type_n(sel_type_n),
        .unit_select_line_n(sel_n), .drive(drive), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // Index every 16 cycles while the disk turns
    always @(posedge aclk) begin
        ph <= (ph == 15) ? 0 : ph + 1;
        pins.index_pulse <= spin_on && (ph < 2);
    end

    task summarize;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task wait_bit(input int b, input logic v, input int n);
        int i;
        @(negedge aclk);
        for (i = 0; i < n && drive[b] !== v; i++) @(negedge aclk);
        chk(drive[b] === v, "output late");
    endtask
    task hold_bit(input int b, input logic v, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge aclk);
            if (drive[b] !== v) break;
        end
        chk(drive[b] === v, "output early");
    endtask
    task axw(input logic [31:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task axr(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task sel_check(input logic [2:0] u, input logic v);
        @(posedge aclk);
        cm_unit <= u;
        repeat (6) @(negedge aclk);
        chk(drive.select_ready === v, "select match");
    endtask

    task t_reset;
        axr(STATUS_OFS);
        chk(d[11:0] === 12'h003 && d[23:21] === UNIT_RST, "reset status");
        axr(32'h0000_0010);
        chk(r === RESP_DECERR && d === 32'h0, "unmapped read");
        axw(32'h0000_0010, 32'h7);
        chk(r === RESP_DECERR, "unmapped write");
    endtask
    task t_start;
        @(posedge aclk);
        pins.run_switch <= 1'b1;
        pins.door_locked <= 1'b0;
        spin_on <= 1'b1;
        hold_bit(SP, 1'b0, 8);
        @(posedge aclk);
        pins.door_locked <= 1'b1;
        wait_bit(SP, 1'b1, 8);
        hold_bit(HL, 1'b0, 100);
        wait_bit(HL, 1'b1, 200);
        @(posedge aclk);
        pins.heads_home <= 1'b0;
        pins.head_motion <= 1'b1;
        repeat (3) @(posedge aclk);
        pins.head_motion <= 1'b0;
        hold_bit(DR, 1'b0, 8);
        wait_bit(DR, 1'b1, 30);
        chk(drive.ready_lamp === 1'b1 && drive.on_cylinder_lamp === 1'b1, "lamps");
    endtask
    task t_select;
        int u;
        axw(CTRL_OFS, 32'h5);
        chk(r === RESP_OKAY, "write response");
        cm_bin <= 1'b1;
        for (u = 0; u < 8; u++) sel_check(u[2:0], u == 5);
        axw(CTRL_OFS, 32'h2);
        cm_bin <= 1'b0;
        sel_check(3'h2, 1'b1);
        sel_check(3'h1, 1'b0);
        sel_check(3'h2, 1'b1);
        @(posedge aclk);
        pins.fault_detect <= 1'b1;
        repeat (3) @(posedge aclk);
        pins.fault_detect <= 1'b0;
        wait_bit(SR, 1'b0, 8);
        hold_bit(SR, 1'b0, 10);
        axw(CTRL_OFS, 32'hA);
        wait_bit(SR, 1'b1, 8);
        axw(CTRL_OFS, 32'h5);
        sel_check(3'h1, 1'b0);
    endtask
    task t_lowspeed;
        @(posedge aclk);
        spin_on <= 1'b0;
        hold_bit(HL, 1'b1, 15);
        wait_bit(HL, 1'b0, 50);
        wait_bit(DR, 1'b0, 4);
        wait_bit(RH, 1'b1, 4);
        @(posedge aclk);
        spin_on <= 1'b1;
        hold_bit(HL, 1'b0, 790);
        wait_bit(HL, 1'b1, 400);
    endtask
    task t_aclow;
        @(posedge aclk);
        pins.line_ac_present <= 1'b0;
        hold_bit(LP, 1'b0, 25);
        wait_bit(LP, 1'b1, 20);
        hold_bit(HL, 1'b1, 10);
        @(posedge aclk);
        pins.sector_pulse <= 1'b1;
        repeat (2) @(posedge aclk);
        pins.sector_pulse <= 1'b0;
        wait_bit(HL, 1'b0, 10);
        @(posedge aclk);
        pins.line_ac_present <= 1'b1;
    endtask
    task t_stop;
        @(posedge aclk);
        pins.run_switch <= 1'b0;
        repeat (8) @(posedge aclk);
        axr(STATUS_OFS);
        chk(d[12] === 1'b0 && r === RESP_OKAY, "run gate");
        @(posedge aclk);
        pins.heads_home <= 1'b1;
        wait_bit(SP, 1'b0, 6);
        hold_bit(DU, 1'b0, 60);
        @(posedge aclk);
        spin_on <= 1'b0;
        wait_bit(DU, 1'b1, 70);
        chk(drive.load_lamp === 1'b1, "load lamp");
    endtask
    task t_dclow;
        @(posedge aclk);
        pins.supply_ok <= 1'b0;
        wait_bit(SL, 1'b1, 6);
        wait_bit(SF, 1'b0, 6);
    endtask

    initial begin
        errors = 0;
        tests_run = 0;
        ph = 0;
        aresetn = 1'b0;
        pins = 10'h1E4; // Cartridge, door, supply, line AC, heads home
        spin_on = 1'b0;
        cm_bin = 1'b1;
        cm_unit = 3'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 32'h0;
        wdata = 32'h0;
        araddr = 32'h0;
        wstrb = 4'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_start;
        t_select;
        t_lowspeed;
        t_aclow;
        t_stop;
        t_dclow;
        summarize;
    end
    initial begin
        #(50 * 20000);
        errors++;
        summarize;
    end
endmodule
